// [core/bridge_edid_ctrl_regs.sv]
`timescale 1ns/10ps
`default_nettype none

module bridge_edid_ctrl_regs #(
   parameter int CEC_INT_DIV = bridge_edid_pkg::CEC_INT_DIV
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        indirect_rd_done,
   input  wire logic [15:0] indirect_rd_upper,
   output logic      [15:0] indirect_data_upper,
   input  wire logic        mode_strap_pin0,
   input  wire logic        hdmi_power_sense_pin,
   input  wire logic        hdmi_rx_irq,
   input  wire logic        hdcp_tx_irq,
   input  wire logic        cfg_done_in,
   input  wire logic        init_done_in,
   input  wire logic        config_checksum_pass_valid,
   input  wire logic        config_checksum_pass_ok,
   input  wire logic        id_cksum_valid,
   input  wire logic        id_cksum_ok,
   input  wire logic        remote_load_done,
   output logic             display_id_ram_reload,
   output logic             display_id_ram_wipe,
   input  wire logic        ram_reload_done,
   input  wire logic        cec_ext_osc_pin,
   output logic             cec_timebase_tick,
   output logic             ddc_display_id_block,
   output logic      [6:0]  display_id_slave_addr,
   output logic             ddc_ram_write_en,
   input  wire logic        ddc_clock_pin,
   input  wire logic        ddc_data_pin_i,
   output logic             ddc_data_pin_o,
   output logic             ddc_data_pin_oe,
   input  wire logic        ddc_data_drive_low,
   output logic             ddc_start_det,
   output logic             ddc_stop_det
);

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   logic [7:0] byte2_q;
   logic [7:0] byte3_q;
   logic       cec_src_q;
   logic       cec_en_q;
   logic       wipe_q;
   logic       reload_q;
   logic       block_q;
   logic [6:0] slave_addr_q;
   logic       wp_q;
   logic [2:0] hold_q;
   logic [3:0] filt_q;
   logic [1:0] out_dly_q;
   logic [7:0] status_q;
   logic [7:0] rdata_q;

   wire wr_ctl = reg_wr && reg_addr == bridge_edid_pkg::OFS_BRIDGE_CTRL;

   // ---------------------------------------------------------------
   // Indirect data bytes
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         byte2_q <= bridge_edid_pkg::RST_DATA_BYTE;
         byte3_q <= bridge_edid_pkg::RST_DATA_BYTE;
      end else if (indirect_rd_done) begin
         byte2_q <= indirect_rd_upper[7:0];
         byte3_q <= indirect_rd_upper[15:8];
      end else if (reg_wr) begin
         if (reg_addr == bridge_edid_pkg::OFS_DATA_BYTE2) begin
            byte2_q <= reg_wdata;
         end
         if (reg_addr == bridge_edid_pkg::OFS_DATA_BYTE3) begin
            byte3_q <= reg_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bridge control
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cec_src_q <= 1'b0;
         cec_en_q  <= 1'b0;
      end else if (wr_ctl) begin
         cec_src_q <= reg_wdata[bridge_edid_pkg::CTL_CEC_SRC];
         cec_en_q  <= reg_wdata[bridge_edid_pkg::CTL_CEC_EN];
      end
   end

   // Set by write wins over completion in the same cycle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         reload_q <= 1'b0;
         wipe_q   <= 1'b0;
      end else if (wr_ctl && reg_wdata[bridge_edid_pkg::CTL_RELOAD]) begin
         reload_q <= 1'b1;
         wipe_q   <= reg_wdata[bridge_edid_pkg::CTL_WIPE];
      end else if (ram_reload_done) begin
         reload_q <= 1'b0;
         wipe_q   <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Strap capture after reset release
   // ---------------------------------------------------------------
   logic       strap1_q;
   logic       strap2_q;
   logic       strap3_q;
   logic [1:0] strap_wait_q;
   logic       strap_taken_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strap1_q <= 1'b0;
         strap2_q <= 1'b0;
         strap3_q <= 1'b0;
      end else begin
         strap1_q <= mode_strap_pin0;
         strap2_q <= strap1_q;
         strap3_q <= strap2_q;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strap_wait_q  <= 2'h0;
         strap_taken_q <= 1'b0;
         block_q       <= 1'b0;
      end else if (!strap_taken_q) begin
         if (strap_wait_q != 2'h3) begin
            strap_wait_q <= strap_wait_q + 2'h1;
         end else if (strap2_q == strap3_q) begin
            block_q       <= strap3_q;
            strap_taken_q <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bridge status
   // ---------------------------------------------------------------
   logic pwr1_q;
   logic pwr2_q;
   logic pwr3_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pwr1_q <= 1'b0;
         pwr2_q <= 1'b0;
         pwr3_q <= 1'b0;
      end else begin
         pwr1_q <= hdmi_power_sense_pin;
         pwr2_q <= pwr1_q;
         pwr3_q <= pwr2_q;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         status_q <= bridge_edid_pkg::RST_STATUS;
      end else begin
         if (pwr2_q == pwr3_q) begin
            status_q[bridge_edid_pkg::STS_PWR_SENSE] <= pwr3_q;
         end
         status_q[bridge_edid_pkg::STS_HDMI_IRQ] <= hdmi_rx_irq;
         status_q[bridge_edid_pkg::STS_HDCP_IRQ] <= hdcp_tx_irq;
         status_q[bridge_edid_pkg::STS_CFG_DONE] <= cfg_done_in;
         status_q[bridge_edid_pkg::STS_INIT_DONE] <=
            init_done_in && cfg_done_in &&
            status_q[bridge_edid_pkg::STS_CFG_DONE];
         if (remote_load_done) begin
            status_q[bridge_edid_pkg::STS_REM_LOADED] <= 1'b1;
         end else if (wr_ctl && reg_wdata[bridge_edid_pkg::CTL_RELOAD]) begin
            status_q[bridge_edid_pkg::STS_REM_LOADED] <= 1'b0;
         end
         if (config_checksum_pass_valid) begin
            status_q[bridge_edid_pkg::STS_CONFIG_CHECKSUM_PASS] <= config_checksum_pass_ok;
         end
         if (id_cksum_valid) begin
            status_q[bridge_edid_pkg::STS_ID_CKSUM] <= id_cksum_ok;
         end
      end
   end

   // ---------------------------------------------------------------
   // Display ID and DDC configuration
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slave_addr_q <= bridge_edid_pkg::RST_SLAVE_ADDR;
         wp_q         <= bridge_edid_pkg::RST_WP;
         hold_q       <= bridge_edid_pkg::RST_HOLD;
         filt_q       <= bridge_edid_pkg::RST_FILTER;
         out_dly_q    <= bridge_edid_pkg::RST_OUT_DLY;
      end else if (reg_wr) begin
         case (reg_addr)
            bridge_edid_pkg::OFS_SLAVE_ADDR: begin
               slave_addr_q <= reg_wdata[7:bridge_edid_pkg::ADDR_LSB];
               wp_q         <= reg_wdata[bridge_edid_pkg::ADDR_WP];
            end
            bridge_edid_pkg::OFS_FILTER_CFG: begin
               hold_q <= reg_wdata[bridge_edid_pkg::HOLD_LSB +: 3];
               filt_q <= reg_wdata[bridge_edid_pkg::FILT_LSB +: 4];
            end
            bridge_edid_pkg::OFS_OUT_DLY_CFG: begin
               out_dly_q <= reg_wdata[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Read back
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            bridge_edid_pkg::OFS_DATA_BYTE2:  rdata_q <= byte2_q;
            bridge_edid_pkg::OFS_DATA_BYTE3:  rdata_q <= byte3_q;
            bridge_edid_pkg::OFS_BRIDGE_CTRL:
               rdata_q <= {3'h0, cec_src_q, cec_en_q, wipe_q, reload_q,
                           block_q};
            bridge_edid_pkg::OFS_BRIDGE_STAT: rdata_q <= status_q;
            bridge_edid_pkg::OFS_SLAVE_ADDR:  rdata_q <= {slave_addr_q, wp_q};
            bridge_edid_pkg::OFS_FILTER_CFG:
               rdata_q <= {1'b0, hold_q, filt_q};
            bridge_edid_pkg::OFS_OUT_DLY_CFG:
               rdata_q <= {6'h00, out_dly_q};
            default:                          rdata_q <= 8'h00;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // CEC timebase
   // ---------------------------------------------------------------
   logic        osc1_q;
   logic        osc2_q;
   logic        osc3_q;
   logic [12:0] int_div_q;
   logic [9:0]  ext_div_q;
   logic        tick_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         osc1_q <= 1'b0;
         osc2_q <= 1'b0;
         osc3_q <= 1'b0;
      end else begin
         osc1_q <= cec_ext_osc_pin;
         osc2_q <= osc1_q;
         osc3_q <= osc2_q;
      end
   end

   wire osc_rise = osc2_q && !osc3_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         int_div_q <= 13'h0000;
         ext_div_q <= 10'h000;
         tick_q    <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (!cec_en_q) begin
            int_div_q <= 13'h0000;
            ext_div_q <= 10'h000;
         end else if (!cec_src_q) begin
            if (int_div_q == 13'(CEC_INT_DIV - 1)) begin
               int_div_q <= 13'h0000;
               tick_q    <= 1'b1;
            end else begin
               int_div_q <= int_div_q + 13'h0001;
            end
         end else if (osc_rise) begin
            if (ext_div_q == 10'(bridge_edid_pkg::CEC_EXT_DIV - 1)) begin
               ext_div_q <= 10'h000;
               tick_q    <= 1'b1;
            end else begin
               ext_div_q <= ext_div_q + 10'h001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // DDC input filtering
   // ---------------------------------------------------------------
   logic [1:0] pin_raw;
   logic [1:0] pin_flt;
   wire  [4:0] filt_cyc = 5'(filt_q * bridge_edid_pkg::FILT_UNIT_CYC);

   assign pin_raw = {ddc_clock_pin, ddc_data_pin_i};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_flt
         ddc_glitch_filter u_flt (
            .mclk    (mclk),
            .nrst    (nrst),
            .pin     (pin_raw[gi]),
            .width   (filt_cyc),
            .level_q (pin_flt[gi])
         );
      end
   endgenerate

   wire scl = pin_flt[1];
   wire sda = pin_flt[0];

   // ---------------------------------------------------------------
   // Start / stop qualification
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      QUAL_IDLE  = 3'b001,
      QUAL_START = 3'b010,
      QUAL_STOP  = 3'b100
   } qual_e;

   qual_e      qual_q;
   logic       sda_prev_q;
   logic       scl_prev_q;
   logic [5:0] hold_cnt_q;
   logic       start_q;
   logic       stop_q;
   wire  [5:0] hold_cyc = 6'(hold_q * bridge_edid_pkg::HOLD_UNIT_CYC);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         qual_q     <= QUAL_IDLE;
         sda_prev_q <= 1'b1;
         scl_prev_q <= 1'b1;
         hold_cnt_q <= 6'h00;
         start_q    <= 1'b0;
         stop_q     <= 1'b0;
      end else begin
         sda_prev_q <= sda;
         scl_prev_q <= scl;
         start_q    <= 1'b0;
         stop_q     <= 1'b0;
         case (qual_q)
            QUAL_IDLE: begin
               hold_cnt_q <= 6'h00;
               if (scl && sda_prev_q && !sda) begin
                  qual_q <= QUAL_START;
               end else if (scl && !sda_prev_q && sda) begin
                  qual_q <= QUAL_STOP;
               end
            end
            QUAL_START: begin
               if (!scl || sda) begin
                  qual_q <= QUAL_IDLE;
               end else if (hold_cnt_q >= hold_cyc) begin
                  start_q <= 1'b1;
                  qual_q  <= QUAL_IDLE;
               end else begin
                  hold_cnt_q <= hold_cnt_q + 6'h01;
               end
            end
            QUAL_STOP: begin
               if (!scl || !sda) begin
                  qual_q <= QUAL_IDLE;
               end else if (hold_cnt_q >= hold_cyc) begin
                  stop_q <= 1'b1;
                  qual_q <= QUAL_IDLE;
               end else begin
                  hold_cnt_q <= hold_cnt_q + 6'h01;
               end
            end
            default: begin
               qual_q <= QUAL_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Data output delay after clock falls
   // ---------------------------------------------------------------
   logic [6:0] dly_cnt_q;
   logic       oe_q;
   wire  [6:0] dly_cyc = 7'(bridge_edid_pkg::DLY_BASE_CYC +
                            out_dly_q * bridge_edid_pkg::DLY_STEP_CYC);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dly_cnt_q <= 7'h00;
         oe_q      <= 1'b0;
      end else if (scl_prev_q && !scl) begin
         dly_cnt_q <= dly_cyc;
      end else if (dly_cnt_q > 7'h01) begin
         dly_cnt_q <= dly_cnt_q - 7'h01;
      end else if (dly_cnt_q == 7'h01) begin
         dly_cnt_q <= 7'h00;
         oe_q      <= ddc_data_drive_low && !block_q;
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   logic       blk_out_q;
   logic       wr_en_q;
   logic       pin_o_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         blk_out_q <= 1'b0;
         wr_en_q   <= 1'b0;
         pin_o_q   <= 1'b0;
      end else begin
         blk_out_q <= block_q;
         wr_en_q   <= !wp_q && !block_q;
         pin_o_q   <= 1'b0;
      end
   end

   assign reg_rdata             = rdata_q;
   assign indirect_data_upper   = {byte3_q, byte2_q};
   assign display_id_ram_reload = reload_q;
   assign display_id_ram_wipe   = wipe_q;
   assign cec_timebase_tick     = tick_q;
   assign ddc_display_id_block  = blk_out_q;
   assign display_id_slave_addr = slave_addr_q;
   assign ddc_ram_write_en      = wr_en_q;
   assign ddc_data_pin_o        = pin_o_q;
   assign ddc_data_pin_oe       = oe_q;
   assign ddc_start_det         = start_q;
   assign ddc_stop_det          = stop_q;

endmodule

`default_nettype wire

// [core/bridge_edid_pkg.sv]
`default_nettype none
package bridge_edid_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_DATA_BYTE2   = 8'h4D;
   localparam logic [7:0] OFS_DATA_BYTE3   = 8'h4E;
   localparam logic [7:0] OFS_BRIDGE_CTRL  = 8'h4F;
   localparam logic [7:0] OFS_BRIDGE_STAT  = 8'h50;
   localparam logic [7:0] OFS_SLAVE_ADDR   = 8'h51;
   localparam logic [7:0] OFS_FILTER_CFG   = 8'h52;
   localparam logic [7:0] OFS_OUT_DLY_CFG  = 8'h53;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTL_CEC_SRC    = 4;
   localparam int CTL_CEC_EN     = 3;
   localparam int CTL_WIPE       = 2;
   localparam int CTL_RELOAD     = 1;
   localparam int CTL_DDC_BLOCK  = 0;
   localparam int STS_PWR_SENSE  = 7;
   localparam int STS_HDMI_IRQ   = 6;
   localparam int STS_HDCP_IRQ   = 5;
   localparam int STS_INIT_DONE  = 4;
   localparam int STS_REM_LOADED = 3;
   localparam int STS_CFG_DONE   = 2;
   localparam int STS_CONFIG_CHECKSUM_PASS  = 1;
   localparam int STS_ID_CKSUM   = 0;
   localparam int ADDR_LSB       = 1;
   localparam int ADDR_WP        = 0;
   localparam int HOLD_LSB       = 4;
   localparam int FILT_LSB       = 0;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_DATA_BYTE   = 8'h00;
   localparam logic [7:0] RST_STATUS      = 8'h03;
   localparam logic [6:0] RST_SLAVE_ADDR  = 7'h50;
   localparam logic       RST_WP          = 1'b0;
   localparam logic [2:0] RST_HOLD        = 3'h1;
   localparam logic [3:0] RST_FILTER      = 4'hE;
   localparam logic [1:0] RST_OUT_DLY     = 2'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int HOLD_UNIT_NS   = 40;
   localparam int FILT_UNIT_NS   = 5;
   localparam int DLY_BASE_NS    = 240;
   localparam int DLY_STEP_NS    = 40;
   localparam int HOLD_UNIT_CYC  = HOLD_UNIT_NS * CLK_MHZ / 1000;
   localparam int FILT_UNIT_CYC  = FILT_UNIT_NS * CLK_MHZ / 1000;
   localparam int DLY_BASE_CYC   = DLY_BASE_NS * CLK_MHZ / 1000;
   localparam int DLY_STEP_CYC   = DLY_STEP_NS * CLK_MHZ / 1000;
   localparam int CEC_HZ         = 32768;
   localparam int EXT_OSC_HZ     = 25000000;
   localparam int CEC_INT_DIV    = CLK_MHZ * 1000000 / CEC_HZ;
   localparam int CEC_EXT_DIV    = EXT_OSC_HZ / CEC_HZ;

endpackage
`default_nettype wire

// [core/ddc_glitch_filter.sv]
`timescale 1ns/10ps
`default_nettype none

module ddc_glitch_filter (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       pin,
   input  wire logic [4:0] width,
   output logic            level_q
);

   // ---------------------------------------------------------------
   // Three-stage synchroniser
   // ---------------------------------------------------------------
   logic       s1_q;
   logic       s2_q;
   logic       s3_q;
   logic [4:0] cnt_q;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ---------------------------------------------------------------
   // Accept a new level after width+1 stable cycles
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_q   <= 5'h00;
         level_q <= 1'b1;
      end else if (s2_q == s3_q && s3_q != level_q) begin
         if (cnt_q >= width) begin
            level_q <= s3_q;
            cnt_q   <= 5'h00;
         end else begin
            cnt_q <= cnt_q + 5'h01;
         end
      end else begin
         cnt_q <= 5'h00;
      end
   end

endmodule

`default_nettype wire

// [test/bridge_edid_ctrl_regs_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module bridge_edid_ctrl_regs_chk #(
   parameter int CEC_INT_DIV = 8
) (
   input wire logic        mclk,
   input wire logic        nrst,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        indirect_rd_done,
   input wire logic [15:0] indirect_rd_upper,
   input wire logic [15:0] indirect_data_upper,
   input wire logic        display_id_ram_reload,
   input wire logic        display_id_ram_wipe,
   input wire logic        ram_reload_done,
   input wire logic        ddc_display_id_block,
   input wire logic [6:0]  display_id_slave_addr,
   input wire logic        ddc_data_pin_oe,
   input wire logic        ddc_start_det,
   input wire logic        ddc_clock_pin,
   input wire logic        ddc_data_pin_i
);
   logic [7:0] wd_q;
   logic [7:0] ra_q;
   logic       rd_q;
   always_ff @(posedge mclk) begin
      wd_q <= reg_wdata;
      ra_q <= reg_addr;
      rd_q <= reg_rd;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence reload_wr;
      reg_wr && reg_addr == 8'h4F && reg_wdata[1];
   endsequence
   sequence loader_idle;
      !display_id_ram_reload && !display_id_ram_wipe;
   endsequence
   sequence start_cond;
      ddc_clock_pin && !ddc_data_pin_i;
   endsequence
   slave_addr_a: assert property (
      reg_wr && reg_addr == 8'h51 |=> display_id_slave_addr == wd_q[7:1])
      else $error("slave address not loaded");
   wipe_alone_a: assert property (
      !display_id_ram_reload |-> !display_id_ram_wipe)
      else $error("wipe without reload");
   reload_start_a: assert property (
      reload_wr |=> display_id_ram_reload && display_id_ram_wipe == wd_q[2])
      else $error("reload not started");
   reload_end_a: assert property (
      ram_reload_done && !(reg_wr && reg_addr == 8'h4F) |=> loader_idle)
      else $error("reload not cleared");
   block_quiet_a: assert property (
      ddc_display_id_block |-> !ddc_data_pin_oe)
      else $error("data driven while blocked");
   indirect_load_a: assert property (
      indirect_rd_done |=> indirect_data_upper == $past(indirect_rd_upper))
      else $error("indirect data not loaded");
   init_order_a: assert property (
      rd_q && ra_q == 8'h50 && reg_rdata[4] |-> reg_rdata[2])
      else $error("init done before config done");
   start_cond_a: assert property (
      ddc_start_det |-> start_cond)
      else $error("start without start condition");
endmodule
bind bridge_edid_ctrl_regs bridge_edid_ctrl_regs_chk #(
   .CEC_INT_DIV(CEC_INT_DIV)
) u_chk (.*);
`default_nettype wire

// [test/ddc_source_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ddc_source_model (
   input  wire logic mclk,
   input  wire logic reload,
   output logic      reload_done,
   output logic      scl,
   output logic      sda
);
   int n = 0;
   initial begin
      reload_done = 1'b0;
      scl = 1'b1;
      sda = 1'b1;
   end
   // Loader answers a reload request after 20 cycles
   always @(negedge mclk) begin
      n = reload ? n + 1 : 0;
      reload_done <= (n == 20);
   end
   task automatic drive(input logic c, input logic d, input int cyc);
      scl = c;
      sda = d;
      repeat (cyc) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// [test/bridge_edid_ctrl_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module bridge_edid_ctrl_regs_tb;
   logic        mclk, nrst, reg_wr, reg_rd, indirect_rd_done, sda;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [15:0] indirect_rd_upper, indirect_data_upper;
   logic        mode_strap_pin0, hdmi_power_sense_pin, hdmi_rx_irq;
   logic        hdcp_tx_irq, cfg_done_in, init_done_in, config_checksum_pass_valid;
   logic        config_checksum_pass_ok, id_cksum_valid, id_cksum_ok, remote_load_done;
   logic        display_id_ram_reload, display_id_ram_wipe, ram_reload_done;
   logic        cec_ext_osc_pin, cec_timebase_tick, ddc_display_id_block;
   logic [6:0]  display_id_slave_addr;
   logic        ddc_ram_write_en, ddc_clock_pin, ddc_data_pin_i;
   logic        ddc_data_pin_o, ddc_data_pin_oe, ddc_data_drive_low;
   logic        ddc_start_det, ddc_stop_det;
   int          failures = 0;
   int          n_tests = 0;
   int          n_start = 0;
   int          n_stop = 0;
   logic [7:0]  adr [8] = '{8'h4D, 8'h4E, 8'h4F, 8'h50,
      8'h51, 8'h52, 8'h53, 8'h60};
   logic [7:0]  r0 [8] = '{8'h00, 8'h00, 8'h00, 8'h03,
      8'hA0, 8'h1E, 8'h00, 8'h00};
   logic [7:0]  wv [8] = '{8'hFF, 8'hFF, 8'hF8, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'hFF};
   logic [7:0]  r1 [8] = '{8'hFF, 8'hFF, 8'h18, 8'h03,
      8'hFF, 8'h7F, 8'h03, 8'h00};
   // Open-drain data line with pull-up
   assign ddc_data_pin_i = sda & ~ddc_data_pin_oe;
   bridge_edid_ctrl_regs #(.CEC_INT_DIV(8)) u_bridge_edid_ctrl_regs (.*);
   ddc_source_model u_ddc_source_model (
      .mclk       (mclk),
      .reload     (display_id_ram_reload),
      .reload_done(ram_reload_done),
      .scl        (ddc_clock_pin),
      .sda        (sda)
   );
   always @(posedge mclk) begin
      if (ddc_start_det === 1'b1)
         n_start <= n_start + 1;
      if (ddc_stop_det === 1'b1)
         n_stop <= n_stop + 1;
   end
   task automatic stop_test;
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic dn = 1'b0);
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr, indirect_rd_done} = {a, d, 1'b1, dn};
      @(negedge mclk);
      {reg_wr, indirect_rd_done} = 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge mclk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge mclk);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask
   task automatic ticks(input int c, input logic [15:0] e);
      logic [15:0] k = '0;
      repeat (10) @(negedge mclk);
      repeat (c) begin
         @(negedge mclk);
         k += cec_timebase_tick;
      end
      chk(k, e);
   endtask
   task automatic pulse(input logic ok);
      @(negedge mclk);
      {config_checksum_pass_ok, id_cksum_ok} = {ok, ok};
      {remote_load_done, config_checksum_pass_valid, id_cksum_valid} = '1;
      @(negedge mclk);
      {remote_load_done, config_checksum_pass_valid, id_cksum_valid} = '0;
      repeat (5) @(negedge mclk);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   initial forever #20 cec_ext_osc_pin = ~cec_ext_osc_pin;
   initial begin
      #50us;
      failures++;
      stop_test();
   end
   initial begin
      nrst = 1'b0;
      {reg_wr, reg_rd, indirect_rd_done, mode_strap_pin0, hdcp_tx_irq,
       hdmi_power_sense_pin, hdmi_rx_irq, cfg_done_in, init_done_in,
       config_checksum_pass_valid, config_checksum_pass_ok, id_cksum_valid, id_cksum_ok,
       remote_load_done, cec_ext_osc_pin, ddc_data_drive_low} = '0;
      {reg_addr, reg_wdata, indirect_rd_upper} = '0;
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
      foreach (adr[i]) rd(adr[i], r0[i]);
      foreach (adr[i]) wr(adr[i], wv[i]);
      foreach (adr[i]) rd(adr[i], r1[i]);
      chk(indirect_data_upper, 16'hFFFF);
      chk(ddc_ram_write_en, 1'b0);
      wr(8'h51, 8'hA0);
      repeat (2) @(negedge mclk);
      chk(ddc_ram_write_en, 1'b1);
      ticks(40, 0);
      wr(8'h4F, 8'h08);
      ticks(40, 5);
      wr(8'h4F, 8'h10);
      wr(8'h4F, 8'h18);
      ticks(6200, 1);
      indirect_rd_upper = 16'hA55A;
      wr(8'h4D, 8'h00, 1'b1);
      rd(8'h4E, 8'hA5);
      rd(8'h4D, 8'h5A);
      wr(8'h4F, 8'h0C);
      rd(8'h4F, 8'h08);
      wr(8'h4F, 8'h0E);
      chk({display_id_ram_reload, display_id_ram_wipe}, 2'b11);
      repeat (30) @(negedge mclk);
      rd(8'h4F, 8'h08);
      {hdmi_power_sense_pin, hdmi_rx_irq, hdcp_tx_irq, init_done_in} = '1;
      pulse(1'b0);
      rd(8'h50, 8'hE8);
      cfg_done_in = 1'b1;
      pulse(1'b1);
      rd(8'h50, 8'hFF);
      u_ddc_source_model.drive(1'b1, 1'b0, 10);
      u_ddc_source_model.drive(1'b1, 1'b1, 40);
      u_ddc_source_model.drive(1'b1, 1'b0, 40);
      u_ddc_source_model.drive(1'b0, 1'b0, 20);
      u_ddc_source_model.drive(1'b0, 1'b1, 20);
      u_ddc_source_model.drive(1'b1, 1'b1, 60);
      chk(n_start, 0);
      u_ddc_source_model.drive(1'b1, 1'b0, 120);
      chk(n_start, 1);
      u_ddc_source_model.drive(1'b1, 1'b1, 100);
      chk(n_stop, 1);
      wr(8'h52, 8'h70);
      wr(8'h53, 8'h03);
      ddc_data_drive_low = 1'b1;
      u_ddc_source_model.drive(1'b0, 1'b0, 60);
      chk(ddc_data_pin_oe, 1'b0);
      u_ddc_source_model.drive(1'b0, 1'b0, 40);
      chk({ddc_data_pin_oe, ddc_data_pin_o}, 2'b10);
      nrst = 1'b0;
      mode_strap_pin0 = 1'b1;
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
      repeat (90) @(negedge mclk);
      rd(8'h4F, 8'h01);
      chk({ddc_display_id_block, ddc_ram_write_en, ddc_data_pin_oe},
          3'b100);
      stop_test();
   end
endmodule
`default_nettype wire
